//--- src/pee_pkg.sv
// Constants shared by the parallel EEPROM host controller and its pin sequencer.
// Assumes a 100 MHz system clock and a device that keeps its own program timing.
// Function
// R01: Device drives stored byte only with write strobe high, chip select and output enable low.
// R02: Device floats the data bus when chip select or output enable is high.
// R03: Writes need chip select and write strobe low with output enable held high.
// R04: Host may strobe a write on either write strobe or chip select line.
// R05: Device captures address on the later falling edge of the two strobes.
// R06: Device captures data on the earlier rising edge of the two strobes.
// R07: Device erases and programs the byte itself within 5 ms.
// R08: Each write strobe rise restarts a 100 us byte load window timer.
// R09: Strobe falling within the window defers programming; host keeps loads within it; host times its window from GAP_CYC cycles after the strobe rise.
// R10: Host spaces byte loads between 0.1 us and 100 us.
// R11: Device ignores write strobe pulses shorter than 20 ns.
// R12: Device inhibits writes for 5 to 10 ms after power-up.
// R13: Host waits 100 us after power-up before its first read.
// R14: Host holds each write strobe pulse low for at least 100 ns.
// R15: While programming, reading the last byte returns bit seven complemented.
// R16: While programming, successive reads toggle data bit six.
// R17: Loads within the window fill a 128-byte page chosen by upper nine bits.
// R18: Host issues no new write until the previous program cycle has ended.
package pee_pkg;
	localparam int ADDR_W          = 16;
	localparam int DATA_W          = 8;
	localparam int CLK_PERIOD_NS   = 10;
	// Printed times, each in its own unit
	localparam int READ_ACCESS_NS  = 150;
	localparam int STROBE_LOW_NS   = 100;
	localparam int LOAD_GAP_MIN_NS = 100;
	localparam int LOAD_WINDOW_US  = 100;
	localparam int PWRUP_READ_US   = 100;
	localparam int PWRUP_WRITE_MS  = 10;
	localparam int PROGRAM_MS      = 5;
	localparam int FLOAT_NS        = 50;
	// Cycle counts: least times round up, longest round down
	localparam int READ_CYC   = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC    = (LOAD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC  = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int PUR_CYC    = PWRUP_READ_US * 1000 / CLK_PERIOD_NS;
	localparam int PUW_CYC    = PWRUP_WRITE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PROG_CYC   = PROGRAM_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PAGE_LSB   = 7;
	localparam int POLL_BIT   = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int CNT_W      = 24;
	typedef enum logic [1:0] {PEE_OP_READ, PEE_OP_WRITE, PEE_OP_POLL} pee_op_t;
endpackage

//--- src/pee_seq_if.sv
// Request and answer bundle between the host controller and its pin sequencer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface pee_seq_if;
	import pee_pkg::*;
	logic              start;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;
	modport ctl (output start, output wr, output addr, output wdata, input done, input rdata);
	modport seq (input start, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

//--- src/pee_pin_seq.sv
// One bus cycle on the EEPROM pins: a read or a write strobed on the write line.
// Assumes the caller keeps requests spaced and has passed the power-up waits.
`timescale 1ns/1ns
`default_nettype none
module pee_pin_seq
	import pee_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Request side
	pee_seq_if.seq           rq,
	// Device pins
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dq_o,
	output logic             dq_oe,
	input  wire logic [DATA_W-1:0] dq_i
);
	typedef enum logic [2:0] {S_IDLE, S_RD, S_WR, S_REL, S_GAP} pee_ps_t;
	pee_ps_t          st_q, st_d;
	logic [7:0]        cnt_q, cnt_d;
	logic              ce_q, ce_d, oe_q, oe_d, we_q, we_d, drv_q, drv_d, done_q, done_d;
	logic [ADDR_W-1:0] a_q, a_d;
	logic [DATA_W-1:0] w_q, w_d, r_q, r_d;

	// Next state of the pin sequence
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; ce_d = ce_q; oe_d = oe_q; we_d = we_q;
		drv_d = drv_q; a_d = a_q; w_d = w_q; r_d = r_q; done_d = 1'b0;
		unique case (st_q)
			S_IDLE: if (rq.start) begin
				a_d = rq.addr; w_d = rq.wdata; cnt_d = 8'h00; ce_d = 1'b0;
				if (rq.wr) begin
					// Output enable stays high so the device sees a write
					oe_d = 1'b1; we_d = 1'b0; drv_d = 1'b1; st_d = S_WR; // R03 R04
				end else begin
					we_d = 1'b1; oe_d = 1'b0; drv_d = 1'b0; st_d = S_RD; // R01
				end
			end
			S_RD: begin
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(READ_CYC - 1)) begin
					r_d = dq_i; ce_d = 1'b1; oe_d = 1'b1; cnt_d = 8'h00; st_d = S_REL; // R02
				end
			end
			S_WR: begin
				cnt_d = cnt_q + 8'h01;
				// Strobe held the full width, far above the glitch filter
				if (cnt_q == 8'(STROBE_CYC - 1)) begin
					we_d = 1'b1; cnt_d = 8'h00; st_d = S_GAP; // R14 R11
				end
			end
			S_REL: begin
				// Wait out the device's float time before anyone turns the bus
				cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(FLOAT_CYC - 1)) begin
					done_d = 1'b1; st_d = S_IDLE;
				end
			end
			S_GAP: begin
				// Data held past the rise, then chip select and drive drop
				ce_d = 1'b1; drv_d = 1'b0; cnt_d = cnt_q + 8'h01;
				if (cnt_q == 8'(GAP_CYC - 1)) begin
					done_d = 1'b1; st_d = S_IDLE; // R10
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= S_IDLE; cnt_q <= 8'h00; ce_q <= 1'b1; oe_q <= 1'b1; we_q <= 1'b1;
			drv_q <= 1'b0; a_q <= '0; w_q <= '0; r_q <= '0; done_q <= 1'b0;
		end else begin
			st_q <= st_d; cnt_q <= cnt_d; ce_q <= ce_d; oe_q <= oe_d; we_q <= we_d;
			drv_q <= drv_d; a_q <= a_d; w_q <= w_d; r_q <= r_d; done_q <= done_d;
		end
	end

	assign ce_n     = ce_q;
	assign oe_n     = oe_q;
	assign we_n     = we_q;
	assign addr     = a_q;
	assign dq_o     = w_q;
	assign dq_oe    = drv_q;
	assign rq.done  = done_q;
	assign rq.rdata = r_q;
endmodule
`default_nettype wire

//--- src/pee_host.sv
// Host controller for an asynchronous 64K x 8 parallel EEPROM.
// Assumes pins sampled synchronously; device times its own program cycle.
`timescale 1ns/1ns
`default_nettype none
module pee_host
	import pee_pkg::*;
#(
	parameter int PUR_CYCLES    = PUR_CYC,
	parameter int PUW_CYCLES    = PUW_CYC,
	parameter int WINDOW_CYCLES = WINDOW_CYC,
	parameter int PROG_CYCLES   = PROG_CYC
)(
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RESET,
	// User command port
	input  wire logic              REQ_VALID,
	input  wire logic [1:0]        REQ_OP,
	input  wire logic [ADDR_W-1:0] REQ_ADDR,
	input  wire logic [DATA_W-1:0] REQ_WDATA,
	output logic                   REQ_READY,
	output logic                   RSP_VALID,
	output logic [DATA_W-1:0]      RSP_RDATA,
	output logic                   PROG_BUSY,
	// EEPROM pins
	output logic                   EE_CE_N,
	output logic                   EE_OE_N,
	output logic                   EE_WE_N,
	output logic [ADDR_W-1:0]      EE_ADDR,
	output logic [DATA_W-1:0]      EE_DQ_O,
	output logic                   EE_DQ_OE,
	input  wire logic [DATA_W-1:0] EE_DQ_I
);
	typedef enum logic [1:0] {H_WAIT, H_IDLE, H_RUN} pee_hs_t;
	pee_seq_if sq();
	pee_hs_t          st_q, st_d;
	logic [CNT_W-1:0] up_q, up_d, win_q, win_d, prog_q, prog_d;
	logic             rd_ok_q, rd_ok_d, wr_ok_q, wr_ok_d, rdy_q, rdy_d, rv_q, rv_d;
	logic             start_q, start_d, wr_q, wr_d, busy_q, busy_d, poll_q, poll_d;
	logic [ADDR_W-1:0] a_q, a_d, last_q, last_d;
	logic [DATA_W-1:0] w_q, w_d, rd_q, rd_d, last_w_q, last_w_d, prev_q, prev_d;
	logic             page_ok;

	// Same 128-byte page as the load in progress
	assign page_ok = (REQ_ADDR[ADDR_W-1:PAGE_LSB] == last_q[ADDR_W-1:PAGE_LSB]); // R17

	// Power-up waits, byte load window and program-time tracking
	always_comb begin
		up_d = up_q; rd_ok_d = rd_ok_q; wr_ok_d = wr_ok_q;
		win_d = (win_q != '0) ? win_q - 1'b1 : win_q;
		prog_d = (prog_q != '0) ? prog_q - 1'b1 : prog_q;
		busy_d = busy_q;
		if (up_q != CNT_W'(PUW_CYCLES)) up_d = up_q + 1'b1;
		if (up_q >= CNT_W'(PUR_CYCLES)) rd_ok_d = 1'b1; // R13
		if (up_q >= CNT_W'(PUW_CYCLES)) wr_ok_d = 1'b1; // R12
		// Window ran out with a load pending: the device is now programming
		if (busy_q && win_q == CNT_W'(1)) prog_d = CNT_W'(PROG_CYCLES); // R08 R07
		if (busy_q && win_q == '0 && prog_q == CNT_W'(1)) busy_d = 1'b0;
		// A finished write, GAP_CYC cycles after its strobe rise, restarts the window
		if (sq.done && wr_q) begin
			win_d = CNT_W'(WINDOW_CYCLES); busy_d = 1'b1; // R08
		end
	end

	// Command acceptance and responses
	always_comb begin
		st_d = st_q; rdy_d = 1'b0; rv_d = 1'b0; start_d = 1'b0; wr_d = wr_q;
		a_d = a_q; w_d = w_q; rd_d = rd_q; last_d = last_q; last_w_d = last_w_q;
		prev_d = prev_q; poll_d = poll_q;
		unique case (st_q)
			H_WAIT: if (rd_ok_q) begin
				st_d = H_IDLE; rdy_d = 1'b1;
			end
			H_IDLE: begin
				rdy_d = 1'b1;
				if (REQ_VALID && rdy_q) begin
					rdy_d = 1'b0; a_d = REQ_ADDR; w_d = REQ_WDATA; poll_d = 1'b0;
					if (REQ_OP == 2'(PEE_OP_WRITE)) begin
						// Writes wait for lockout and for any program cycle; a page
						// load continues only inside the window on the same page
						if (wr_ok_q && prog_q == '0 && (!busy_q || (win_q > CNT_W'(2) && page_ok))) begin
							wr_d = 1'b1; start_d = 1'b1; st_d = H_RUN; // R09 R18
							last_d = REQ_ADDR; last_w_d = REQ_WDATA;
						end else begin
							rdy_d = 1'b1;
						end
					end else if (busy_q && win_q != '0) begin
						rdy_d = 1'b1; // Reads would break a page load in progress
					end else begin
						wr_d = 1'b0; start_d = 1'b1; st_d = H_RUN;
						poll_d = (REQ_OP == 2'(PEE_OP_POLL));
						if (poll_d) a_d = last_q;
					end
				end
			end
			H_RUN: if (sq.done) begin
				st_d = H_IDLE; rdy_d = 1'b1;
				if (!wr_q) begin
					rv_d = 1'b1; rd_d = sq.rdata; prev_d = sq.rdata;
				end
			end
			default: st_d = H_WAIT;
		endcase
	end

	// Polling ends the busy view early: bit seven true and bit six steady
	logic poll_done;
	assign poll_done = poll_q && sq.done && !wr_q
		&& sq.rdata[POLL_BIT] == last_w_q[POLL_BIT] // R15
		&& sq.rdata[TOGGLE_BIT] == prev_q[TOGGLE_BIT]; // R16

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			st_q <= H_WAIT; up_q <= '0; win_q <= '0; prog_q <= '0; rd_ok_q <= 1'b0;
			wr_ok_q <= 1'b0; rdy_q <= 1'b0; rv_q <= 1'b0; start_q <= 1'b0; wr_q <= 1'b0;
			busy_q <= 1'b0; poll_q <= 1'b0; a_q <= '0; w_q <= '0; rd_q <= '0;
			last_q <= '0; last_w_q <= '0; prev_q <= '0;
		end else begin
			st_q <= st_d; up_q <= up_d; win_q <= win_d; rd_ok_q <= rd_ok_d;
			wr_ok_q <= wr_ok_d; rdy_q <= rdy_d; rv_q <= rv_d; start_q <= start_d; wr_q <= wr_d;
			prog_q <= poll_done ? '0 : prog_d;
			busy_q <= poll_done ? 1'b0 : busy_d;
			poll_q <= poll_d; a_q <= a_d; w_q <= w_d; rd_q <= rd_d;
			last_q <= last_d; last_w_q <= last_w_d; prev_q <= prev_d;
		end
	end

	assign sq.start = start_q;
	assign sq.wr    = wr_q;
	assign sq.addr  = a_q;
	assign sq.wdata = w_q;

	// Pin sequencer; its outputs are registers, so the pins come from flops
	pee_pin_seq u_seq (
		.clk  (CLK_SYS),
		.rst  (RESET),
		.rq   (sq.seq),
		.ce_n (EE_CE_N),
		.oe_n (EE_OE_N),
		.we_n (EE_WE_N),
		.addr (EE_ADDR),
		.dq_o (EE_DQ_O),
		.dq_oe(EE_DQ_OE),
		.dq_i (EE_DQ_I)
	);

	assign REQ_READY = rdy_q;
	assign RSP_VALID = rv_q;
	assign RSP_RDATA = rd_q;
	assign PROG_BUSY = busy_q;
endmodule
`default_nettype wire

//--- verification/pee_host_assertions.sv
// Pin checks for the EEPROM host, bound to its top module.
// Assumes the bind hands on the lockout and read-wait counts.
`timescale 1ns/1ns
`default_nettype none
module pee_host_assertions
	import pee_pkg::*;
#(
	parameter int PUR_CYCLES = 50,
	parameter int PUW_CYCLES = 200
)(
	// Clock and reset
	input wire logic              CLK_SYS,
	input wire logic              RESET,
	// Watched outputs
	input wire logic              RSP_VALID,
	input wire logic              PROG_BUSY,
	input wire logic              EE_CE_N,
	input wire logic              EE_OE_N,
	input wire logic              EE_WE_N,
	input wire logic [ADDR_W-1:0] EE_ADDR,
	input wire logic [DATA_W-1:0] EE_DQ_O,
	input wire logic              EE_DQ_OE
);
	logic [23:0] up_q, up_d;
	logic [7:0]  lo_q, lo_d, hi_q, hi_d;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	// Saturating counts: cycles since reset, strobe low run, strobe high run
	always_comb begin
		up_d = (up_q < 24'(PUW_CYCLES)) ? up_q + 24'h1 : up_q;
		lo_d = EE_WE_N ? 8'h0 : lo_q + {7'h0, lo_q != 8'hff};
		hi_d = EE_WE_N ? hi_q + {7'h0, hi_q != 8'hff} : 8'h0;
	end
	// Gap count starts full so the first strobe after reset is not flagged
	always_ff @(posedge CLK_SYS) begin
		up_q <= RESET ? 24'h0 : up_d;
		lo_q <= RESET ? 8'h0 : lo_d;
		hi_q <= RESET ? 8'hff : hi_d;
	end
	property p_wr_mode; !EE_WE_N |-> EE_OE_N && !EE_CE_N && EE_DQ_OE; endproperty
	a_wr_mode: assert property (p_wr_mode) else $error("bad write mode");
	property p_rd_float; !EE_OE_N |-> !EE_DQ_OE && EE_WE_N; endproperty
	a_rd_float: assert property (p_rd_float) else $error("host drives during read");
	property p_strobe; $rose(EE_WE_N) |-> lo_q >= 8'(STROBE_CYC) && !EE_CE_N; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too short");
	property p_gap; $fell(EE_WE_N) |-> hi_q >= 8'(GAP_CYC); endproperty
	a_gap: assert property (p_gap) else $error("load gap too short");
	property p_lock; !EE_WE_N |-> up_q >= 24'(PUW_CYCLES); endproperty
	a_lock: assert property (p_lock) else $error("write in lockout");
	property p_rd_wait; !EE_OE_N |-> up_q >= 24'(PUR_CYCLES); endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read too early");
	property p_hold; !EE_WE_N ##1 !EE_WE_N |-> $stable(EE_ADDR) && $stable(EE_DQ_O); endproperty
	a_hold: assert property (p_hold) else $error("address or data moved");
	property p_busy; $rose(EE_WE_N) |-> ##[1:20] PROG_BUSY; endproperty
	a_busy: assert property (p_busy) else $error("busy not raised");
	c_write: cover property ($rose(EE_WE_N));
	c_read: cover property (RSP_VALID);
	c_done: cover property ($fell(PROG_BUSY));
endmodule
bind pee_host pee_host_assertions #(.PUR_CYCLES(PUR_CYCLES), .PUW_CYCLES(PUW_CYCLES)) chk_inst (
	.CLK_SYS(CLK_SYS), .RESET(RESET), .RSP_VALID(RSP_VALID), .PROG_BUSY(PROG_BUSY),
	.EE_CE_N(EE_CE_N), .EE_OE_N(EE_OE_N), .EE_WE_N(EE_WE_N), .EE_ADDR(EE_ADDR),
	.EE_DQ_O(EE_DQ_O), .EE_DQ_OE(EE_DQ_OE));
`default_nettype wire

//--- verification/pee_dev_model.sv
// Behavioural EEPROM seen from its pins, with times scaled down.
// Assumes the bench resolves nothing else: dq is the bus level.
`timescale 1ns/1ns
`default_nettype none
module pee_dev_model
	import pee_pkg::*;
#(
	parameter int WIN_NS  = 400,
	parameter int PROG_NS = 1000,
	parameter int LOCK_NS = 1500,
	parameter int ACC_NS  = 150
)(
	// Device pins
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic [ADDR_W-1:0] addr,
	// Host side of the data bus
	input  wire logic [DATA_W-1:0] host_d,
	input  wire logic              host_oe,
	output logic [DATA_W-1:0]      dq
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] pg [int];
	logic [DATA_W-1:0] last_d, rd;
	logic [ADDR_W-1:0] a_lat;
	logic              timing = 0, busy = 0, tog = 0;
	time               t_fall, t_rise, t_prog, t_rd;
	initial dq = 8'h00;
	// Address on the later falling strobe; a new load halts the timer
	always @(negedge we_n or negedge ce_n) if (!ce_n && !we_n && oe_n) begin
		t_fall = $time;
		timing = 0;
		// Strobes and address switch in one step; let the address settle first
		#1 a_lat = addr;
	end
	// Data on the earlier rising strobe; glitches and lockout ignored
	always @(posedge we_n or posedge ce_n)
		if ((we_n ^ ce_n) && oe_n && !busy && $time >= LOCK_NS && $time - t_fall >= 20) begin
			pg[int'(a_lat)] = dq;
			last_d = dq;
			t_rise = $time;
			timing = 1;
		end
	// Each read start while programming flips the toggle bit
	always @(negedge oe_n) begin
		t_rd = $time;
		if (busy) tog = ~tog;
	end
	// Timer, program cycle and bus driver; a floating bus keeps changing
	always begin
		#1;
		if (timing && we_n && $time - t_rise >= WIN_NS) begin
			timing = 0;
			busy = 1;
			t_prog = $time;
		end
		if (busy && $time - t_prog >= PROG_NS) begin
			foreach (pg[i]) mem[i] = pg[i];
			pg.delete();
			busy = 0;
		end
		rd = busy ? {~last_d[7], tog, last_d[5:0]} :
			(mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff);
		if (host_oe) dq = host_d;
		else if (!ce_n && !oe_n && we_n && $time - t_rd >= ACC_NS) dq = rd;
		else dq = ~dq;
	end
endmodule
`default_nettype wire

//--- verification/pee_host_tb_top.sv
// Self-checking bench for the EEPROM host against the pin model.
// Assumes shortened lockout, window and program counts.
`timescale 1ns/1ns
`default_nettype none
module pee_host_tb_top;
	import pee_pkg::*;
	logic              clk = 0, rst = 1, vld = 0, rdy, rv, busy, ce_n, oe_n, we_n, d_oe;
	logic [1:0]        op = 2'h0;
	logic [ADDR_W-1:0] ad = 16'h0, ee_a;
	logic [DATA_W-1:0] wd = 8'h0, rdat, d_o, dq;
	int                fail_count = 0, n_tests = 0;
	pee_host #(.PUR_CYCLES(50), .PUW_CYCLES(200), .WINDOW_CYCLES(40), .PROG_CYCLES(100)) pee_host_inst (
		.CLK_SYS(clk), .RESET(rst), .REQ_VALID(vld), .REQ_OP(op), .REQ_ADDR(ad), .REQ_WDATA(wd),
		.REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rdat), .PROG_BUSY(busy), .EE_CE_N(ce_n),
		.EE_OE_N(oe_n), .EE_WE_N(we_n), .EE_ADDR(ee_a), .EE_DQ_O(d_o), .EE_DQ_OE(d_oe), .EE_DQ_I(dq));
	pee_dev_model pee_dev_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(ee_a),
		.host_d(d_o), .host_oe(d_oe), .dq(dq));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	// One request, held until taken; reads wait for their answer
	task automatic req(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		vld <= 1'b1;
		op <= o;
		ad <= a;
		wd <= d;
		// Ready stays high over a refused request, so hold until it drops
		do @(posedge clk); while (rdy !== 1'b1 && ++n < 3000);
		do @(posedge clk); while (rdy !== 1'b0 && ++n < 3000);
		vld <= 1'b0;
		q = 8'h0;
		if (o != 2'h1) begin
			do @(posedge clk); while (rv !== 1'b1 && ++n < 3200);
			q = rdat;
		end
		if (n >= 3000) fail_count++;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		// A write just taken raises busy only after its strobe has finished
		do @(posedge clk); while (busy !== 1'b1 && ++n < 3000);
		do @(posedge clk); while (busy !== 1'b0 && ++n < 3000);
		if (n >= 3000) fail_count++;
	endtask
	// Blank read, page load of two bytes, then a write to another page
	task automatic t_page();
		logic [7:0] q;
		req(2'h0, 16'h8000, 8'h0, q);
		chk(q, 8'hff);
		req(2'h1, 16'h2b80, 8'ha1, q);
		req(2'h1, 16'h2bff, 8'h3c, q);
		req(2'h1, 16'h2c00, 8'hc3, q);
		wait_idle();
		req(2'h0, 16'h2b80, 8'h0, q);
		chk(q, 8'ha1);
		req(2'h0, 16'h2bff, 8'h0, q);
		chk(q, 8'h3c);
		req(2'h0, 16'h2c00, 8'h0, q);
		chk(q, 8'hc3);
	endtask
	// Byte write watched by two polls during programming
	task automatic t_byte();
		logic [7:0] p1, p2, q;
		req(2'h1, 16'h1234, 8'h5a, q);
		req(2'h2, 16'h0, 8'h0, p1);
		req(2'h2, 16'h0, 8'h0, p2);
		chk(p1 & 8'h80, 8'h80);
		chk((p1 ^ p2) & 8'h40, 8'h40);
		wait_idle();
		req(2'h0, 16'h1234, 8'h0, q);
		chk(q, 8'h5a);
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_page();
		t_byte();
		tally_and_finish();
	end
	// Tests need about a thousand cycles, so this span means a hang
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
